// >>> shared/adc_stat_pkg.sv
package adc_stat_pkg;
  // ----------------------------------------
  // Register map (word index, byte = 4*index)
  // ----------------------------------------
  localparam logic [7:0] FILT_CFG_IDX = 8'h07;
  localparam logic [7:0] CHECK_CTRL_IDX = 8'h08;
  localparam logic [7:0] ACT_STAT_IDX = 8'h0A;
  localparam logic [7:0] FILT_CFG_RST = 8'h00;
  localparam logic [7:0] CHECK_CTRL_RST = 8'h00;
  localparam logic [7:0] ACT_STAT_RST = 8'h00;
  // Check control field positions
  localparam int TEMP_GO_BIT = 0;
  localparam int TEMP_MODE_LSB = 1;
  localparam int VOLT_GO_BIT = 4;
  localparam int VOLT_MODE_LSB = 5;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam real CLK_MHZ = 125.0;
  localparam real AUX_WAIT0_MS = 4.3;
  localparam real AUX_WAIT1_MS = 2.3;
  localparam real AUX_WAIT2_MS = 1.3;
  localparam int AUX_WAIT0_CYC = int'($ceil(AUX_WAIT0_MS * CLK_MHZ * 1000.0));
  localparam int AUX_WAIT1_CYC = int'($ceil(AUX_WAIT1_MS * CLK_MHZ * 1000.0));
  localparam int AUX_WAIT2_CYC = int'($ceil(AUX_WAIT2_MS * CLK_MHZ * 1000.0));
  localparam logic [1:0] AUX_SEL_RSVD = 2'h3;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] aux_filter_wait_sel;
    logic [2:0] shunt_filter_cutoff;
    logic [2:0] cell_filter_cutoff;
  } filt_cfg_s;
  typedef struct packed {
    logic reserved;
    logic fact_crc_done;
    logic cust_crc_done;
    logic temp_comparator_active;
    logic voltage_comparator_active;
    logic cs_adc_active;
    logic aux_adc_active;
    logic main_adc_active;
  } act_stat_s;
  typedef enum logic [1:0] {
    CHK_IDLE = 2'b00,
    CHK_RUN = 2'b01,
    CHK_STOP = 2'b10
  } chk_state_e;
endpackage

// >>> design/adc_status_filter_config.sv
`timescale 1ns/1ps
`default_nettype none
module adc_status_filter_config #(
  parameter int AUX_WAIT0 = adc_stat_pkg::AUX_WAIT0_CYC,
  parameter int AUX_WAIT1 = adc_stat_pkg::AUX_WAIT1_CYC,
  parameter int AUX_WAIT2 = adc_stat_pkg::AUX_WAIT2_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cs_adc_on,
  input wire logic aux_adc_on,
  input wire logic main_adc_on,
  input wire logic temp_check_done,
  input wire logic volt_check_done,
  input wire logic temp_check_abort,
  input wire logic volt_check_abort,
  input wire logic aux_conv_start,
  output logic temp_comparator_enable,
  output logic volt_comparator_enable,
  output logic [1:0] temp_check_mode,
  output logic [1:0] volt_check_mode,
  output logic aux_sample_valid,
  output adc_stat_pkg::filt_cfg_s filter_config,
  output logic [15:0] cell_cutoff_dhz,
  output logic [15:0] shunt_cutoff_dhz
);
  import adc_stat_pkg::*;

  localparam int CW = 20;

  if (AUX_WAIT0 < 1 || AUX_WAIT1 < 1 || AUX_WAIT2 < 1 ||
      AUX_WAIT0 >= 2**CW || AUX_WAIT1 >= 2**CW ||
      AUX_WAIT2 >= 2**CW) begin : g_bad_wait
    $error("aux settle counts out of range");
  end

  // ----------------------------------------
  // Cut-off table, in tenths of a hertz
  // ----------------------------------------
  function automatic logic [15:0] cutoff_dhz(input logic [2:0] code);
    case (code)
      3'h0: cutoff_dhz = 16'h0041;
      3'h1: cutoff_dhz = 16'h0082;
      3'h2: cutoff_dhz = 16'h0104;
      3'h3: cutoff_dhz = 16'h0212;
      3'h4: cutoff_dhz = 16'h0456;
      3'h6: cutoff_dhz = 16'h1770;
      default: cutoff_dhz = 16'h0960;
    endcase
  endfunction

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic [7:0] idx;
  logic addr_ok;
  logic wr_en;
  logic sel_cfg;
  logic sel_ctrl;
  logic sel_stat;
  filt_cfg_s cfg_reg;
  logic [1:0] tmode_reg;
  logic [1:0] vmode_reg;
  act_stat_s stat_reg;
  logic [31:0] rdata_next;

  assign idx = paddr[9:2];
  assign sel_cfg = (idx == FILT_CFG_IDX);
  assign sel_ctrl = (idx == CHECK_CTRL_IDX);
  assign sel_stat = (idx == ACT_STAT_IDX);
  assign addr_ok = (paddr[31:10] == 22'h0) && (paddr[1:0] == 2'h0) &&
                   (sel_cfg || sel_ctrl || sel_stat);
  assign wr_en = psel && penable && pready && pwrite && addr_ok;

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (sel_cfg) begin
      rdata_next[7:0] = cfg_reg;
    end else if (sel_ctrl) begin
      rdata_next[TEMP_MODE_LSB +: 2] = tmode_reg;
      rdata_next[VOLT_MODE_LSB +: 2] = vmode_reg;
    end else if (sel_stat) begin
      rdata_next[7:0] = stat_reg;
    end
  end

  // No wait state: pready is high in the first access cycle, the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite && addr_ok)
        prdata <= rdata_next;
      else
        prdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= FILT_CFG_RST;
    end else if (wr_en && sel_cfg) begin
      cfg_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmode_reg <= CHECK_CTRL_RST[TEMP_MODE_LSB +: 2];
      vmode_reg <= CHECK_CTRL_RST[VOLT_MODE_LSB +: 2];
    end else if (wr_en && sel_ctrl) begin
      tmode_reg <= pwdata[TEMP_MODE_LSB +: 2];
      vmode_reg <= pwdata[VOLT_MODE_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_config <= FILT_CFG_RST;
      cell_cutoff_dhz <= 16'h0000;
      shunt_cutoff_dhz <= 16'h0000;
      temp_check_mode <= 2'h0;
      volt_check_mode <= 2'h0;
    end else begin
      filter_config <= cfg_reg;
      cell_cutoff_dhz <= cutoff_dhz(cfg_reg.cell_filter_cutoff);
      shunt_cutoff_dhz <= cutoff_dhz(cfg_reg.shunt_filter_cutoff);
      temp_check_mode <= tmode_reg;
      volt_check_mode <= vmode_reg;
    end
  end

  // ----------------------------------------
  // Comparator self-check sequencing
  // ----------------------------------------
  // Channel 0 is temperature, channel 1 is voltage. The go bit is a
  // write-only strobe; go with mode 0 aborts a running check.
  logic [1:0] go_wr;
  logic [1:0] mode_nz;
  logic [1:0] done_in;
  logic [1:0] abort_in;
  logic [1:0] run_reg;
  logic [1:0] comp_reg;

  assign go_wr[0] = wr_en && sel_ctrl && pwdata[TEMP_GO_BIT];
  assign go_wr[1] = wr_en && sel_ctrl && pwdata[VOLT_GO_BIT];
  assign mode_nz[0] = |pwdata[TEMP_MODE_LSB +: 2];
  assign mode_nz[1] = |pwdata[VOLT_MODE_LSB +: 2];
  assign done_in = {volt_check_done, temp_check_done};
  assign abort_in = {volt_check_abort, temp_check_abort};

  for (genvar i = 0; i < 2; i++) begin : g_chk
    chk_state_e state_reg;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        state_reg <= CHK_IDLE;
        run_reg[i] <= 1'b0;
        comp_reg[i] <= 1'b0;
      end else begin
        case (state_reg)
          CHK_IDLE: begin
            if (go_wr[i] && mode_nz[i]) begin
              state_reg <= CHK_RUN;
              run_reg[i] <= 1'b1;
              comp_reg[i] <= 1'b1;
            end
          end
          CHK_RUN: begin
            if (done_in[i] || abort_in[i] || (go_wr[i] && !mode_nz[i])) begin
              state_reg <= CHK_STOP;
              comp_reg[i] <= 1'b0;
            end
          end
          CHK_STOP: begin
            state_reg <= CHK_IDLE;
            run_reg[i] <= 1'b0;
          end
          default: begin
            state_reg <= CHK_IDLE;
            run_reg[i] <= 1'b0;
            comp_reg[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_comparator_enable <= 1'b0;
      volt_comparator_enable <= 1'b0;
    end else begin
      temp_comparator_enable <= comp_reg[0];
      volt_comparator_enable <= comp_reg[1];
    end
  end

  // ----------------------------------------
  // Activity status
  // ----------------------------------------
  // Built only from hardware state; no bus write reaches it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= ACT_STAT_RST;
    end else begin
      stat_reg <= '{reserved: 1'b0, fact_crc_done: 1'b0,
                    cust_crc_done: 1'b0,
                    temp_comparator_active: run_reg[0],
                    voltage_comparator_active: run_reg[1],
                    cs_adc_active: cs_adc_on,
                    aux_adc_active: aux_adc_on,
                    main_adc_active: main_adc_on};
    end
  end

  // ----------------------------------------
  // Auxiliary settle wait
  // ----------------------------------------
  // Reserved code falls back to the longest wait, the safe side.
  logic [CW-1:0] wait_len;
  logic [CW-1:0] cnt_reg;
  logic busy_reg;

  always_comb begin
    case (cfg_reg.aux_filter_wait_sel)
      2'h1: wait_len = CW'(AUX_WAIT1);
      2'h2: wait_len = CW'(AUX_WAIT2);
      default: wait_len = CW'(AUX_WAIT0);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      aux_sample_valid <= 1'b0;
    end else if (aux_conv_start) begin
      cnt_reg <= wait_len - CW'(1);
      busy_reg <= 1'b1;
      aux_sample_valid <= 1'b0;
    end else if (busy_reg) begin
      if (cnt_reg == '0) begin
        busy_reg <= 1'b0;
        aux_sample_valid <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg - CW'(1);
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_go_start(int ch);
    go_wr[ch] && mode_nz[ch] && !run_reg[ch];
  endsequence
  property p_temp_set;
    @(posedge pclk) disable iff (!presetn)
      s_go_start(0) |=> run_reg[0] && comp_reg[0];
  endproperty
  a_temp_set: assert property (p_temp_set)
    else $error("temp flag did not set on start");
  property p_volt_set;
    @(posedge pclk) disable iff (!presetn)
      s_go_start(1) |=> run_reg[1] ##1 stat_reg.voltage_comparator_active;
  endproperty
  a_volt_set: assert property (p_volt_set)
    else $error("volt flag did not set on start");
  property p_temp_off_order;
    @(posedge pclk) disable iff (!presetn)
      $fell(comp_reg[0]) |-> run_reg[0] ##1 !run_reg[0];
  endproperty
  a_temp_off_order: assert property (p_temp_off_order)
    else $error("temp flag cleared out of order");
  property p_volt_done;
    @(posedge pclk) disable iff (!presetn)
      comp_reg[1] && volt_check_done |=> !comp_reg[1] ##1 !run_reg[1];
  endproperty
  a_volt_done: assert property (p_volt_done)
    else $error("volt check did not end");
  property p_volt_mode0;
    @(posedge pclk) disable iff (!presetn)
      go_wr[1] && !mode_nz[1] && !run_reg[1] |=> !run_reg[1];
  endproperty
  a_volt_mode0: assert property (p_volt_mode0)
    else $error("volt flag set with mode 0");
  property p_main_stat;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> stat_reg.main_adc_active == $past(main_adc_on) &&
               stat_reg.cs_adc_active == $past(cs_adc_on);
  endproperty
  a_main_stat: assert property (p_main_stat)
    else $error("converter status mismatch");

  property p_aux_wait;
    @(posedge pclk) disable iff (!presetn)
      aux_conv_start |=> !aux_sample_valid [*2];
  endproperty
  a_aux_wait: assert property (p_aux_wait)
    else $error("aux valid too early");

  property p_cell_cut;
    @(posedge pclk) disable iff (!presetn)
      cfg_reg.cell_filter_cutoff == 3'h6 && $stable(cfg_reg) |=>
        cell_cutoff_dhz == 16'h1770;
  endproperty
  a_cell_cut: assert property (p_cell_cut)
    else $error("cell cut-off decode wrong");
endmodule
`default_nettype wire

// >>> verification/adc_status_filter_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_status_filter_config_tb;
  import adc_stat_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  // Short settle waits keep the run brief; expectations use these values
  localparam int W0 = 20;
  localparam int W1 = 10;
  localparam int W2 = 5;
  localparam logic [31:0] filt_addr = 32'(FILT_CFG_IDX) * 4;
  localparam logic [31:0] ctrl_addr = 32'(CHECK_CTRL_IDX) * 4;
  localparam logic [31:0] stat_addr = 32'(ACT_STAT_IDX) * 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic cs_adc_on, aux_adc_on, main_adc_on, aux_conv_start;
  logic temp_check_done, volt_check_done, temp_check_abort, volt_check_abort;
  logic temp_comparator_enable, volt_comparator_enable, aux_sample_valid;
  logic [1:0] temp_check_mode, volt_check_mode;
  logic [15:0] cell_cutoff_dhz, shunt_cutoff_dhz;
  filt_cfg_s filter_config;
  int mismatches = 0;
  int checks = 0;
  logic [15:0] cut_tab [8] = '{16'h0041, 16'h0082, 16'h0104, 16'h0212,
                               16'h0456, 16'h0960, 16'h1770, 16'h0960};
  adc_status_filter_config #(.AUX_WAIT0(W0), .AUX_WAIT1(W1), .AUX_WAIT2(W2))
  dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cs_adc_on(cs_adc_on),
    .aux_adc_on(aux_adc_on), .main_adc_on(main_adc_on),
    .temp_check_done(temp_check_done), .volt_check_done(volt_check_done),
    .temp_check_abort(temp_check_abort), .volt_check_abort(volt_check_abort),
    .aux_conv_start(aux_conv_start),
    .temp_comparator_enable(temp_comparator_enable),
    .volt_comparator_enable(volt_comparator_enable),
    .temp_check_mode(temp_check_mode), .volt_check_mode(volt_check_mode),
    .aux_sample_valid(aux_sample_valid), .filter_config(filter_config),
    .cell_cutoff_dhz(cell_cutoff_dhz), .shunt_cutoff_dhz(shunt_cutoff_dhz));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [31:0] a, d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 1, 0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic reg_wr(input logic [31:0] a, d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk("write error", 0, {31'h0, e});
  endtask
  task automatic reg_rd(input string what, input logic [31:0] a, exp,
                        input logic err_exp = 1'b0);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
    chk("read error", {31'h0, err_exp}, {31'h0, e});
  endtask
  task automatic stop_pulse(input logic [3:0] v);
    @(posedge pclk);
    {temp_check_done, volt_check_done, temp_check_abort,
     volt_check_abort} <= v;
    @(posedge pclk);
    {temp_check_done, volt_check_done, temp_check_abort,
     volt_check_abort} <= 4'h0;
  endtask
  task automatic expect_run(input string what, input logic t, v);
    repeat (5) @(posedge pclk);
    chk(what, {30'h0, t, v}, {30'h0, temp_comparator_enable,
                              volt_comparator_enable});
    reg_rd(what, stat_addr, {27'h0, t, v, 3'h0});
  endtask
  task automatic aux_pulse();
    @(posedge pclk);
    aux_conv_start <= 1'b1;
    @(posedge pclk);
    aux_conv_start <= 1'b0;
  endtask
  // Edges after the one that samples the start pulse until valid is high
  task automatic aux_measure(input string what, input int exp);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (aux_sample_valid !== 1'b1 && n < 100);
    chk(what, exp, n);
  endtask
  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    #100us;
    mismatches++;
    give_verdict();
  end
  initial begin
    int w;
    logic [31:0] d;
    {presetn, psel, penable, pwrite, aux_conv_start} = 5'h0;
    {paddr, pwdata} = 64'h0;
    {cs_adc_on, aux_adc_on, main_adc_on} = 3'h0;
    {temp_check_done, volt_check_done, temp_check_abort,
     volt_check_abort} = 4'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    reg_rd("filter reset", filt_addr, 32'h0);
    reg_rd("ctrl reset", ctrl_addr, 32'h0);
    reg_rd("status reset", stat_addr, 32'h0);
    chk("cell cut reset", 32'(cut_tab[0]), 32'(cell_cutoff_dhz));
    for (int i = 0; i < 8; i++) begin
      d = {24'h0, 2'(i), 3'(7 - i), 3'(i)};
      reg_wr(filt_addr, d);
      reg_rd("filter readback", filt_addr, d);
      chk("filter out", d, 32'(filter_config));
      chk("cell cut", 32'(cut_tab[i]), 32'(cell_cutoff_dhz));
      chk("shunt cut", 32'(cut_tab[7 - i]), 32'(shunt_cutoff_dhz));
    end
    for (int s = 0; s < 4; s++) begin
      w = (s == 1) ? W1 : (s == 2) ? W2 : W0;
      reg_wr(filt_addr, 32'(s) << 6);
      aux_pulse();
      aux_measure("aux settle", w);
    end
    aux_pulse();
    repeat (3) @(posedge pclk);
    aux_pulse();
    aux_measure("aux restart", W0);
    reg_wr(ctrl_addr, 32'h3);
    expect_run("temp start", 1'b1, 1'b0);
    chk("temp mode", 32'h1, 32'(temp_check_mode));
    stop_pulse(4'h8);
    expect_run("temp done", 1'b0, 1'b0);
    reg_wr(ctrl_addr, 32'h7);
    reg_rd("ctrl readback", ctrl_addr, 32'h6);
    expect_run("temp mode3", 1'b1, 1'b0);
    reg_wr(ctrl_addr, 32'h1);
    expect_run("temp mode0 stop", 1'b0, 1'b0);
    reg_wr(ctrl_addr, 32'h5);
    stop_pulse(4'h2);
    expect_run("temp abort", 1'b0, 1'b0);
    reg_wr(ctrl_addr, 32'h10);
    expect_run("volt mode0", 1'b0, 1'b0);
    reg_wr(ctrl_addr, 32'h50);
    expect_run("volt start", 1'b0, 1'b1);
    chk("volt mode", 32'h2, 32'(volt_check_mode));
    stop_pulse(4'h1);
    expect_run("volt abort", 1'b0, 1'b0);
    reg_wr(ctrl_addr, 32'h30);
    stop_pulse(4'h4);
    expect_run("volt done", 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      {cs_adc_on, aux_adc_on, main_adc_on} <= 3'(i);
      repeat (3) @(posedge pclk);
      reg_rd("activity", stat_addr, 32'(i));
      reg_wr(stat_addr, 32'hFF);
      reg_rd("status write", stat_addr, 32'(i));
    end
    reg_rd("unmapped", 32'h0000_0040, 32'h0, 1'b1);
    reg_rd("misaligned", filt_addr + 1, 32'h0, 1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
